// *** roll_regs.svh ***
`ifndef ROLL_REGS_SVH
`define ROLL_REGS_SVH
// horizontal scale codes: each code is one step of the time base
`define ROLL_SCALE_50MS     8'h14
`define ROLL_SCALE_20MS     8'h13
// default record length and trigger position
`define ROLL_REC_LEN_DEF    16
`define ROLL_TRIG_POS_DEF   8
// register offsets of the plain port
`define ROLL_OFS_CTRL       4'h0
`define ROLL_OFS_SCALE      4'h1
`define ROLL_OFS_TRIGPOS    4'h2
`define ROLL_OFS_STATUS     4'h3
`define ROLL_OFS_COUNT      4'h4
// control field positions
`define ROLL_CTRL_RUN       0
`define ROLL_CTRL_NORMAL    1
`define ROLL_CTRL_SINGLE    2
`define ROLL_CTRL_ENV       3
`define ROLL_CTRL_AVG       4
`define ROLL_CTRL_PERSIST   5
// reset values
`define ROLL_CTRL_RST       6'h00
`define ROLL_SCALE_RST      8'h00
`endif

// *** roll_pkg.sv ***
package roll_pkg;
	// acquisition state
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_FREE    = 3'b001,
		ST_PRE     = 3'b010,
		ST_POST    = 3'b011,
		ST_DONE    = 3'b100
	} roll_state_e;
	// one sample handed to the display record
	typedef struct packed {
		logic        valid;
		logic        shift;
		logic [15:0] pos;
		logic [7:0]  data;
	} rec_write_s;
endpackage

// *** roll_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
// two flop synchroniser for one pin level
module roll_sync (
	input  wire logic CLK_IN,
	input  wire logic RST_N_IN,
	input  wire logic ce_in,
	input  wire logic d_in,
	output var  logic q_out
);
	logic meta_reg;
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			meta_reg <= 1'b0;
			q_out    <= 1'b0;
		end else if (ce_in) begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// *** roll_mode_acquisition_ctrl.sv ***
// Behaviour
// - auto trigger mode gives untriggered roll, normal gives triggered, single capture makes either single-sequence.
// - roll is allowed only at a time base of 50 ms per division or slower.
// - roll is off at a time base of 20 ms per division or faster.
// - envelope, averaging or persistence stops roll from starting and ends it when active.
// - untriggered roll writes each sample at the right end and shifts older ones left, no trigger needed.
// - untriggered single-sequence roll halts after one full record of samples.
// - triggered roll enters samples at the trigger position shifting left, then fills rightward after a trigger.
// - continuous triggered roll restarts pretrigger filling after the record completes.
// - triggered single-sequence roll halts when the record is full after the trigger.
// - without single-sequence, roll runs until the run/stop control stops it.
// - going from single capture back to run/stop returns to the continuous variant.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "roll_regs.svh"
module roll_mode_acquisition_ctrl #(
	parameter int REC_LEN  = `ROLL_REC_LEN_DEF,
	parameter int DATA_W   = 8
) (
	input  wire logic               CLK_IN,
	input  wire logic               RST_N_IN,
	input  wire logic               CE_IN,
	input  wire logic [3:0]         ADDR_IN,
	input  wire logic [15:0]        WDATA_IN,
	input  wire logic               WR_IN,
	input  wire logic               RD_IN,
	output var  logic [15:0]        RDATA_OUT,
	input  wire logic               SAMPLE_VALID_IN,
	input  wire logic [DATA_W-1:0]  SAMPLE_DATA_IN,
	input  wire logic               TRIG_PIN_IN,
	output var  roll_pkg::rec_write_s REC_WRITE_OUT,
	output var  logic               ROLL_ACTIVE_OUT,
	output var  logic               ACQ_DONE_OUT
);
	import roll_pkg::*;

	// refuse geometries that the 16 bit counters and the struct cannot carry
	if (REC_LEN < 2 || REC_LEN > 65535) begin : g_bad_len
		$error("REC_LEN out of range");
	end
	if (DATA_W != 8) begin : g_bad_width
		$error("DATA_W must match the record write struct");
	end

	// ************************************************************
	// register port
	// ************************************************************
	logic [5:0]  ctrl_reg;
	logic [7:0]  scale_reg;
	logic [15:0] trig_pos_reg;
	logic [15:0] count_reg;
	roll_state_e state_reg;
	logic        halt_now;
	logic        roll_ok;

	// register selects
	wire wr_ctrl  = WR_IN && (ADDR_IN == `ROLL_OFS_CTRL);
	wire wr_scale = WR_IN && (ADDR_IN == `ROLL_OFS_SCALE);
	wire wr_trig  = WR_IN && (ADDR_IN == `ROLL_OFS_TRIGPOS);

	// control settings
	wire run_ctl     = ctrl_reg[`ROLL_CTRL_RUN];
	wire trig_normal = ctrl_reg[`ROLL_CTRL_NORMAL];
	wire single_seq  = ctrl_reg[`ROLL_CTRL_SINGLE];
	wire inhibit     = ctrl_reg[`ROLL_CTRL_ENV] | ctrl_reg[`ROLL_CTRL_AVG]
		| ctrl_reg[`ROLL_CTRL_PERSIST];

	// control and setting writes
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			ctrl_reg     <= `ROLL_CTRL_RST;
			scale_reg    <= `ROLL_SCALE_RST;
			trig_pos_reg <= 16'(`ROLL_TRIG_POS_DEF);
		end else if (CE_IN) begin
			if (wr_ctrl)
				ctrl_reg <= WDATA_IN[5:0];
			else if (halt_now)
				ctrl_reg[`ROLL_CTRL_RUN] <= 1'b0; // single sequence halt clears run
			if (wr_scale)
				scale_reg <= WDATA_IN[7:0];
			if (wr_trig)
				trig_pos_reg <= WDATA_IN;
		end
	end

	// read mux
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		unique case (ADDR_IN)
			`ROLL_OFS_CTRL:    rd_mux = {10'h000, ctrl_reg};
			`ROLL_OFS_SCALE:   rd_mux = {8'h00, scale_reg};
			`ROLL_OFS_TRIGPOS: rd_mux = trig_pos_reg;
			`ROLL_OFS_STATUS:  rd_mux = {11'h000, roll_ok, ACQ_DONE_OUT, state_reg};
			`ROLL_OFS_COUNT:   rd_mux = count_reg;
			default:           rd_mux = 16'h0000;
		endcase
	end

	// read data one cycle after the strobe
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			RDATA_OUT <= 16'h0000;
		else if (CE_IN)
			RDATA_OUT <= RD_IN ? rd_mux : 16'h0000;
	end

	// ************************************************************
	// trigger pin and mode decode
	// ************************************************************
	logic trig_sync;
	roll_sync u_trig_sync (
		.CLK_IN   (CLK_IN),
		.RST_N_IN (RST_N_IN),
		.ce_in    (CE_IN),
		.d_in     (TRIG_PIN_IN),
		.q_out    (trig_sync)
	);
	logic trig_prev_reg;
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			trig_prev_reg <= 1'b0;
		else if (CE_IN)
			trig_prev_reg <= trig_sync;
	end
	wire trig_edge = trig_sync & ~trig_prev_reg;

	// scale gate: slow enough to roll, fast settings turn it off
	wire scale_slow = (scale_reg >= `ROLL_SCALE_50MS);
	wire scale_fast = (scale_reg <= `ROLL_SCALE_20MS);
	assign roll_ok  = scale_slow & ~scale_fast & ~inhibit;
	wire roll_run   = roll_ok & run_ctl;

	// record geometry
	localparam logic [15:0] LAST_POS = 16'(REC_LEN - 1);
	// trigger position kept left of the right end so one post slot remains
	localparam logic [15:0] PRE_MAX  = 16'(REC_LEN - 2);
	wire [15:0] pre_len  = (trig_pos_reg > PRE_MAX) ? PRE_MAX : trig_pos_reg;
	wire        take     = SAMPLE_VALID_IN;
	wire        pre_full = (count_reg >= pre_len);
	wire        trig_ok  = trig_edge & pre_full;
	wire        rec_end  = (count_reg == LAST_POS);

	// ************************************************************
	// acquisition sequencer
	// ************************************************************
	roll_state_e state_next;
	logic [15:0] count_next;
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		halt_now   = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				count_next = 16'h0000;
				if (roll_run)
					state_next = trig_normal ? ST_PRE : ST_FREE;
			end
			ST_FREE: begin
				if (take && !rec_end)
					count_next = count_reg + 16'h0001;
				if (take && rec_end && single_seq) begin
					state_next = ST_DONE;
					halt_now   = 1'b1;
				end
			end
			ST_PRE: begin
				if (trig_ok) begin
					state_next = ST_POST;
					count_next = pre_len + 16'h0001; // first slot right of trigger
				end else if (take && !pre_full)
					count_next = count_reg + 16'h0001;
			end
			ST_POST: begin
				if (take) begin
					if (rec_end) begin
						count_next = 16'h0000;
						if (single_seq) begin
							state_next = ST_DONE;
							halt_now   = 1'b1;
						end else
							state_next = ST_PRE;
					end else
						count_next = count_reg + 16'h0001;
				end
			end
			ST_DONE: begin
				if (run_ctl && roll_ok)
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
		// leaving roll or flipping trigger mode restarts the sequence
		if (state_reg != ST_IDLE && state_reg != ST_DONE) begin
			if (!roll_run)
				state_next = ST_IDLE;
			else if (trig_normal != (state_reg != ST_FREE))
				state_next = ST_IDLE;
		end
		// clearing single capture while done resumes continuous roll
		if (state_reg == ST_DONE && !single_seq && roll_ok)
			state_next = ST_IDLE;
	end

	// sequencer registers
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_reg <= ST_IDLE;
			count_reg <= 16'h0000;
		end else if (CE_IN) begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// ************************************************************
	// record write stream
	// ************************************************************
	rec_write_s wr_next;
	always_comb begin
		wr_next       = '0;
		wr_next.data  = SAMPLE_DATA_IN;
		unique case (state_reg)
			ST_FREE: begin
				wr_next.valid = take;
				wr_next.shift = 1'b1;
				wr_next.pos   = LAST_POS;
			end
			ST_PRE: begin
				wr_next.valid = take & ~trig_ok;
				wr_next.shift = 1'b1;
				wr_next.pos   = pre_len;
			end
			ST_POST: begin
				wr_next.valid = take;
				wr_next.shift = 1'b0;
				wr_next.pos   = count_reg;
			end
			default: wr_next.valid = 1'b0;
		endcase
		if (!roll_run)
			wr_next.valid = 1'b0;
	end

	// output flops
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			REC_WRITE_OUT   <= '0;
			ROLL_ACTIVE_OUT <= 1'b0;
			ACQ_DONE_OUT    <= 1'b0;
		end else if (CE_IN) begin
			REC_WRITE_OUT   <= wr_next;
			ROLL_ACTIVE_OUT <= (state_next != ST_IDLE) && (state_next != ST_DONE);
			ACQ_DONE_OUT    <= (state_next == ST_DONE);
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_single_end;
		CE_IN && state_reg == ST_POST && take && rec_end && single_seq && roll_run
		&& trig_normal && !wr_ctrl;
	endsequence
	sequence s_free_end;
		CE_IN && state_reg == ST_FREE && take && rec_end && single_seq && roll_run
		&& !trig_normal;
	endsequence
	sequence s_trig_accept;
		CE_IN && state_reg == ST_PRE && trig_ok && roll_run && trig_normal;
	endsequence

	// mode gate: scale and acquisition settings
	chk_scale_fast_off: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && scale_fast |=> !ROLL_ACTIVE_OUT)
		else $error("roll active at fast scale");
	chk_inhibit_ends: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && inhibit |=> !ROLL_ACTIVE_OUT)
		else $error("roll active while inhibited");
	chk_slow_allowed: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_IDLE && scale_slow && !inhibit && run_ctl |=> ROLL_ACTIVE_OUT)
		else $error("roll refused at slow scale");
	chk_scale_reject: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_IDLE && scale_fast |=> state_reg == ST_IDLE)
		else $error("roll started at fast scale");

	// mode selection and continuous running
	chk_mode_select: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_IDLE && roll_run && !wr_ctrl |=>
		state_reg == (trig_normal ? ST_PRE : ST_FREE))
		else $error("wrong roll variant");
	chk_mode_flip: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_FREE && trig_normal |=> state_reg != ST_FREE)
		else $error("untriggered roll kept in normal trigger mode");
	chk_cont_runs: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && (state_reg == ST_FREE || state_reg == ST_PRE || state_reg == ST_POST)
		&& roll_run && !single_seq && (trig_normal == (state_reg != ST_FREE)) |=>
		ROLL_ACTIVE_OUT)
		else $error("continuous roll stopped without run stop");
	chk_single_leave: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_DONE && !single_seq && roll_ok |=> state_reg == ST_IDLE)
		else $error("leaving single sequence did not resume");

	// single sequence halts
	chk_free_single_halt: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		s_free_end |=> ACQ_DONE_OUT && !ROLL_ACTIVE_OUT)
		else $error("untriggered single sequence did not halt");
	chk_trig_single_halt: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		s_single_end |=> ACQ_DONE_OUT && !ROLL_ACTIVE_OUT)
		else $error("single sequence did not halt");
	chk_done_holds: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_DONE |=> !ROLL_ACTIVE_OUT)
		else $error("acquiring straight out of a halt");

	// triggered sequence
	chk_trig_ignored: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_PRE && !pre_full |=> state_reg != ST_POST)
		else $error("early trigger accepted");
	chk_trig_accept: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		s_trig_accept |=> state_reg == ST_POST)
		else $error("valid trigger not accepted");
	chk_cont_restart: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_POST && take && rec_end && !single_seq && roll_run
		&& trig_normal && !wr_ctrl |=> state_reg == ST_PRE && count_reg == 16'h0000)
		else $error("continuous triggered roll did not restart");

	// record write stream
	chk_free_right_end: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_FREE && take && roll_run |=>
		REC_WRITE_OUT.valid && REC_WRITE_OUT.shift && REC_WRITE_OUT.pos == LAST_POS)
		else $error("untriggered sample not at right end");
	chk_pre_entry_pos: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_PRE && take && !trig_ok && roll_run && !wr_trig |=>
		REC_WRITE_OUT.valid && REC_WRITE_OUT.shift && REC_WRITE_OUT.pos == pre_len)
		else $error("pretrigger sample not at trigger position");
	chk_post_no_shift: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && state_reg == ST_POST && take && roll_run |=>
		REC_WRITE_OUT.valid && !REC_WRITE_OUT.shift)
		else $error("shift after trigger");
	chk_write_idle: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && !roll_run |=> !REC_WRITE_OUT.valid)
		else $error("record written while stopped");

	// read port
	chk_rdata_idle: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
		CE_IN && !RD_IN |=> RDATA_OUT == 16'h0000)
		else $error("read data without a read strobe");
endmodule
`default_nettype wire

// *** roll_src_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// stand-in for the digitizer sample source and the trigger detector
module roll_src_model (
	input  wire logic       clk_in,
	output var  logic       sample_valid_out,
	output var  logic [7:0] sample_data_out,
	output var  logic       trig_out
);
	initial begin
		sample_valid_out = 1'b0;
		sample_data_out  = 8'h00;
		trig_out         = 1'b0;
	end
	// one sample pulse; data inverted afterwards so stale values never look valid
	task automatic send(input logic [7:0] d, input int gap);
		@(posedge clk_in);
		sample_valid_out <= 1'b1;
		sample_data_out  <= d;
		@(posedge clk_in);
		sample_valid_out <= 1'b0;
		sample_data_out  <= ~d;
		repeat (gap) @(posedge clk_in);
	endtask
	// trigger level held long enough to cross the two flop sync
	task automatic trig();
		@(posedge clk_in);
		trig_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		trig_out <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// *** tb_roll_mode_acquisition_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "roll_regs.svh"
module tb_roll_mode_acquisition_ctrl;
	import roll_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic        s_valid;
	logic [7:0]  s_data;
	logic        trig;
	rec_write_s  rec;
	logic        active;
	logic        done;
	logic [15:0] last_pos = 16'h0000;
	logic        last_shift = 1'b0;
	logic [7:0]  last_data = 8'h00;
	int          wr_cnt = 0;
	int          miscompares = 0;
	int          checks = 0;
	logic [15:0] v;
	always #25 clk = ~clk;
	roll_src_model src (.clk_in(clk), .sample_valid_out(s_valid), .sample_data_out(s_data),
		.trig_out(trig));
	roll_mode_acquisition_ctrl dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.SAMPLE_VALID_IN(s_valid), .SAMPLE_DATA_IN(s_data), .TRIG_PIN_IN(trig),
		.REC_WRITE_OUT(rec), .ROLL_ACTIVE_OUT(active), .ACQ_DONE_OUT(done));
	// record writes seen at the display side
	always @(posedge clk) begin
		if (rec.valid === 1'b1) begin
			wr_cnt++;
			last_pos = rec.pos;
			last_shift = rec.shift;
			last_data = rec.data;
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rreg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic t_reset();
		chk("active", 16'h0000, {15'h0, active});
		rreg(`ROLL_OFS_CTRL, v);
		chk("ctrl", 16'h0000, v);
		rreg(4'h7, v);
		chk("unmapped", 16'h0000, v);
	endtask
	task automatic t_scale();
		wreg(`ROLL_OFS_SCALE, 16'h0013);
		wreg(`ROLL_OFS_CTRL, 16'h0001);
		settle();
		chk("fast active", 16'h0000, {15'h0, active});
		wreg(`ROLL_OFS_SCALE, 16'h0014);
		settle();
		chk("slow active", 16'h0001, {15'h0, active});
		rreg(`ROLL_OFS_SCALE, v);
		chk("scale", 16'h0014, v);
		src.send(8'h5a, 2);
		chk("free pos", 16'h000f, last_pos);
		chk("free shift", 16'h0001, {15'h0, last_shift});
		chk("free data", 16'h005a, {8'h00, last_data});
	endtask
	// low clock enable freezes the block: no sample taken, no state moved
	task automatic t_freeze();
		int n;
		n = wr_cnt;
		@(posedge clk);
		ce <= 1'b0;
		src.send(8'h77, 2);
		chk("frozen writes", n[15:0], wr_cnt[15:0]);
		chk("frozen active", 16'h0001, {15'h0, active});
		@(posedge clk);
		ce <= 1'b1;
	endtask
	task automatic t_inhibit();
		for (int b = 3; b <= 5; b++) begin
			wreg(`ROLL_OFS_CTRL, 16'h0001 | (16'h0001 << b));
			settle();
			chk("inhibit", 16'h0000, {15'h0, active});
			wreg(`ROLL_OFS_CTRL, 16'h0001);
			settle();
			chk("resume", 16'h0001, {15'h0, active});
		end
	endtask
	task automatic t_free_single();
		int n;
		wreg(`ROLL_OFS_CTRL, 16'h0000);
		wreg(`ROLL_OFS_CTRL, 16'h0005);
		for (int i = 0; i < 16; i++) src.send(i[7:0], 1);
		settle();
		chk("single done", 16'h0001, {15'h0, done});
		chk("single stop", 16'h0000, {15'h0, active});
		rreg(`ROLL_OFS_STATUS, v);
		chk("status", {11'h000, 1'b1, 1'b1, ST_DONE}, v);
		n = wr_cnt;
		src.send(8'h11, 2);
		chk("halted writes", n[15:0], wr_cnt[15:0]);
		wreg(`ROLL_OFS_CTRL, 16'h0001);
		settle();
		chk("back continuous", 16'h0001, {15'h0, active});
	endtask
	task automatic t_trig(input logic single);
		int k;
		wreg(`ROLL_OFS_CTRL, 16'h0000);
		wreg(`ROLL_OFS_CTRL, {13'h0, single, 2'b11});
		settle();
		src.send(8'h01, 0);
		src.trig();
		src.send(8'h02, 2);
		chk("early trig", 16'h0001, {15'h0, last_shift});
		for (int i = 0; i < 8; i++) src.send(i[7:0], 0);
		settle();
		chk("pre pos", 16'h0008, last_pos);
		chk("pre shift", 16'h0001, {15'h0, last_shift});
		rreg(`ROLL_OFS_COUNT, v);
		chk("pre count", 16'h0008, v);
		src.trig();
		src.send(8'h33, 2);
		chk("post shift", 16'h0000, {15'h0, last_shift});
		chk("post pos", 16'h0009, last_pos);
		k = 0;
		while (last_pos !== 16'h000f && k < 20) begin
			src.send(8'h44, 2);
			k++;
		end
		if (k == 20) begin
			miscompares++;
			stop_test();
		end
		settle();
		if (single) begin
			chk("trig done", 16'h0001, {15'h0, done});
			chk("trig stop", 16'h0000, {15'h0, active});
		end else begin
			src.send(8'h55, 2);
			chk("restart pos", 16'h0008, last_pos);
			chk("restart shift", 16'h0001, {15'h0, last_shift});
			chk("still active", 16'h0001, {15'h0, active});
		end
	endtask
	task automatic t_stop();
		wreg(`ROLL_OFS_CTRL, 16'h0002);
		settle();
		chk("run stop", 16'h0000, {15'h0, active});
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		settle();
		t_reset();
		t_scale();
		t_freeze();
		t_inhibit();
		t_free_single();
		t_trig(1'b0);
		t_stop();
		t_trig(1'b1);
		stop_test();
	end
endmodule
`default_nettype wire
